// [shared/dcgc_map.vh]
`ifndef DCGC_MAP_VH
`define DCGC_MAP_VH
// =====================================================================
// Register word indices; the byte address is four times the index
`define DCGC_IDX_CFG      3'h1
`define DCGC_IDX_STAT     3'h2
// Peripheral indices are free choices, placed next after status
`define DCGC_IDX_PERA     3'h3
`define DCGC_IDX_PERB     3'h4
`define DCGC_IDX_RST      3'h0
// Index field and top bit of the byte address
`define DCGC_IDX_LSB      2
`define DCGC_IDX_MSB      4
`define DCGC_ADDR_MSB     31
// Read data outside a read data phase
`define DCGC_RDATA_RST    32'h0000_0000
// =====================================================================
// Gating configuration / status bit positions
`define DCGC_BIT_CORE     0
`define DCGC_BIT_DATA     5
`define DCGC_BIT_IO       6
`define DCGC_BIT_MEM      7
`define DCGC_BIT_FETCH    8
`define DCGC_BIT_ACCEL    9
// Writable mask of configuration register (bits 9..5, 4..1, 0)
`define DCGC_CFG_MASK     16'h03ff
`define DCGC_CFG_RST      16'h0000
`define DCGC_STAT_RST     16'h0000
// Global disable bit inside peripheral register a
`define DCGC_BIT_GDIS     15
`define DCGC_PER_RST      16'h0000
`define DCGC_DOMAINS      6
`endif

// [rtl/dcgc_gate_cell.v]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Gating cell: latch-free enable register plus clock AND
module dcgc_gate_cell (
    input  wire hclk,        // Source clock
    input  wire hresetn,     // Async reset, active low
    input  wire gate_off,    // One stops the gated clock
    output wire clk_out,     // Gated clock
    output reg  clk_on_reg   // Enable as applied
);
    // Enable taken on falling edge so clk_out never glitches
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_on_reg <= 1'b1;  // Clocks run out of reset
        end else begin
            clk_on_reg <= ~gate_off;
        end
    end
    assign clk_out = hclk & clk_on_reg;
endmodule // dcgc_gate_cell
`default_nettype wire

// [rtl/dcgc_top.v]
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcgc_map.vh"
// Functional notes
// - Config held until idle instruction applies it
// - Idle method gates exactly six CPU domains
// - Peripheral register writes gate clocks immediately
// - Global disable gates all except PLLs, RTC, oscillators
// - Small control logic keeps an ungated clock
// - Idle copies config to status, status drives gates
// - Config bits: accel9 fetch8 mem7 io6 data5 core0
// - Status register read-only, same bit positions
module dcgc_top #(
    parameter PERIPH_N = 32  // Peripheral gated clocks (two 16-bit registers)
) (
    input  wire                  hclk,
    input  wire                  hresetn,
    input  wire                  hsel,
    input  wire [31:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output reg  [31:0]           hrdata,
    output wire                  hreadyout,
    output wire                  hresp,
    input  wire                  idle_exec,      // Idle instruction pulse, same clock
    output wire [5:0]            cpu_clk,        // Gated core, data, io, mem, fetch, accel
    output wire [PERIPH_N-1:0]   periph_clk,     // Gated peripheral clocks
    output wire                  ctl_clk,        // Ungated clock for wake logic
    output wire                  global_clock_disable
);
    // =================================================================
    // Register state
    // Sixteen-bit registers sit in the low half of each bus word
    reg  [15:0] cpu_gating_config_reg;   // Pending idle configuration
    reg  [15:0] cpu_gating_status_reg;   // Applied idle state
    reg  [15:0] periph_gating_reg_a;     // Peripheral gates, top bit global
    reg  [15:0] periph_gating_reg_b;     // Peripheral gates
    reg  [15:0] cpu_gating_config_next;  // Configuration after this edge
    reg  [15:0] cpu_gating_status_next;  // Status after this edge
    reg  [15:0] periph_gating_a_next;    // Peripheral register a after this edge
    reg  [15:0] periph_gating_b_next;    // Peripheral register b after this edge
    reg  [31:0] hrdata_next;             // Read word for the coming data phase
    reg  [2:0]  idx_reg;                 // Word index held into data phase
    reg         wr_reg;                  // Write pending in data phase
    wire        take;                    // Address phase accepted
    wire        hit;                     // Address inside this block
    wire        rd_take;                 // Accepted read inside this block
    wire [2:0]  idx_now;                 // Word index of current address phase
    wire [5:0]  cpu_off;                 // Per-domain off from status
    wire [31:0] per_off;                 // Raw peripheral off bits

    // =================================================================
    // Bus handshake
    // No register needs more than one cycle, so no wait state is added
    assign hreadyout = 1'b1;
    // Every access completes; unmapped ones simply read zero
    assign hresp     = 1'b0;
    // Only NONSEQ and SEQ count; this block expects single transfers
    assign take      = hsel & hready & htrans[1];
    // Word index; the two byte-lane bits are ignored
    assign idx_now   = haddr[`DCGC_IDX_MSB:`DCGC_IDX_LSB];
    // Upper address bits must be zero, so aliases of the map read zero
    assign hit       = ~|haddr[`DCGC_ADDR_MSB:`DCGC_IDX_MSB+1];
    // Accepted read of a word inside the map
    assign rd_take   = take & ~hwrite & hit;

    // =================================================================
    // Address phase capture
    // Write data arrives a cycle later, so index and intent are held
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg <= `DCGC_IDX_RST;
            wr_reg  <= 1'b0;
        end else begin
            // Index follows the bus; only wr_reg decides if it is used
            idx_reg <= idx_now;
            // Writes outside the map are dropped here
            wr_reg  <= take & hwrite & hit;
        end
    end

    // =================================================================
    // Next register values
    // Kept combinational so the read path sees the same values
    always @* begin
        // Default: every register holds
        cpu_gating_config_next = cpu_gating_config_reg;
        cpu_gating_status_next = cpu_gating_status_reg;
        periph_gating_a_next   = periph_gating_reg_a;
        periph_gating_b_next   = periph_gating_reg_b;
        // Write lands at the end of its data phase
        if (wr_reg) begin
            case (idx_reg)
                `DCGC_IDX_CFG: begin
                    // Writing config changes no clock by itself
                    cpu_gating_config_next = hwdata[15:0] & `DCGC_CFG_MASK;
                end
                `DCGC_IDX_PERA: begin
                    // Peripheral gates follow at the next falling edge
                    periph_gating_a_next = hwdata[15:0];
                end
                `DCGC_IDX_PERB: begin
                    // Same immediate path for the second bank
                    periph_gating_b_next = hwdata[15:0];
                end
                default: begin
                    // Status has no write path
                    cpu_gating_status_next = cpu_gating_status_reg;
                end
            endcase
        end
        // Idle copies config; a same-cycle config write is seen next idle
        if (idle_exec) begin
            cpu_gating_status_next = cpu_gating_config_reg;
        end
    end

    // =================================================================
    // Register update
    // Clocked by hclk itself, never by a gated clock, so wake works
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // All clocks run after reset; software trims them later
            cpu_gating_config_reg <= `DCGC_CFG_RST;
            cpu_gating_status_reg <= `DCGC_STAT_RST;
            periph_gating_reg_a   <= `DCGC_PER_RST;
            periph_gating_reg_b   <= `DCGC_PER_RST;
        end else begin
            cpu_gating_config_reg <= cpu_gating_config_next;
            cpu_gating_status_reg <= cpu_gating_status_next;
            periph_gating_reg_a   <= periph_gating_a_next;
            periph_gating_reg_b   <= periph_gating_b_next;
        end
    end

    // =================================================================
    // Read data selection
    // Taken from next values, so a write or idle on the same edge shows
    always @* begin
        // Zero outside a read
        hrdata_next = `DCGC_RDATA_RST;
        if (rd_take) begin
            case (idx_now)
                `DCGC_IDX_CFG: begin
                    hrdata_next = {16'h0000, cpu_gating_config_next};
                end
                `DCGC_IDX_STAT: begin
                    // Read-only copy of the applied state
                    hrdata_next = {16'h0000, cpu_gating_status_next};
                end
                `DCGC_IDX_PERA: begin
                    hrdata_next = {16'h0000, periph_gating_a_next};
                end
                `DCGC_IDX_PERB: begin
                    hrdata_next = {16'h0000, periph_gating_b_next};
                end
                default: begin
                    // Unused index reads zero
                    hrdata_next = `DCGC_RDATA_RST;
                end
            endcase
        end
    end

    // =================================================================
    // Read data register
    // Registered so the bus sees a clean value for the whole data phase;
    // it costs no cycle since the data phase follows the capture edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `DCGC_RDATA_RST;
        end else begin
            // Falls back to zero after the data phase
            hrdata <= hrdata_next;
        end
    end

    // =================================================================
    // Gate decisions
    assign global_clock_disable = periph_gating_reg_a[`DCGC_BIT_GDIS];
    // Six domains driven from status copy only
    assign cpu_off = {cpu_gating_status_reg[`DCGC_BIT_ACCEL],
                      cpu_gating_status_reg[`DCGC_BIT_FETCH],
                      cpu_gating_status_reg[`DCGC_BIT_MEM],
                      cpu_gating_status_reg[`DCGC_BIT_IO],
                      cpu_gating_status_reg[`DCGC_BIT_DATA],
                      cpu_gating_status_reg[`DCGC_BIT_CORE]};
    // Global bit is itself a control, not a peripheral gate
    assign per_off = {periph_gating_reg_b,
                      1'b0, periph_gating_reg_a[14:0]};

    // Register file and bus stay on ungated clock so software can wake
    assign ctl_clk = hclk;

    // =================================================================
    // One gating cell per domain; global disable overrides all
    genvar g;
    generate
        for (g = 0; g < `DCGC_DOMAINS; g = g + 1) begin : g_cpu
            dcgc_gate_cell u_cell (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .gate_off   (cpu_off[g] | global_clock_disable),
                .clk_out    (cpu_clk[g]),
                .clk_on_reg ()
            );
        end
        for (g = 0; g < PERIPH_N; g = g + 1) begin : g_per
            dcgc_gate_cell u_cell (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .gate_off   (per_off[g % 32] | global_clock_disable),
                .clk_out    (periph_clk[g]),
                .clk_on_reg ()
            );
        end
    endgenerate
endmodule // dcgc_top
`default_nettype wire

// [tb/dcgc_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks; the falling edge sees each running gated clock high
module dcgc_chk #(
    parameter PERIPH_N = 32
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                idle_exec,
    input wire logic                ctl_clk,
    input wire logic                global_clock_disable,
    input wire logic [31:0]         haddr,
    input wire logic [31:0]         hrdata,
    input wire logic [1:0]          htrans,
    input wire logic [5:0]          cpu_clk,
    input wire logic [PERIPH_N-1:0] periph_clk
);
    default clocking cb @(negedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd_ap = hsel && hready && htrans[1] && !hwrite;  // Read address phase
    wire wr_ap = hsel && hready && htrans[1] && hwrite;   // Write address phase
    a_gdis_spares_ctl: assert property (global_clock_disable [*2] |-> ctl_clk)
        else $error("control clock stopped under global disable");
    a_gdis_all_off: assert property (
        $past(global_clock_disable) |-> (cpu_clk == 6'h00) && (periph_clk == '0))
        else $error("clock running under global disable");
    a_spare_bit_global: assert property (periph_clk[15] == !$past(global_clock_disable))
        else $error("peripheral clock 15 wrong");
    // Only an idle pulse or a global change may move the CPU clocks
    a_cfg_held: assert property (
        !$past(idle_exec, 2) && ($past(global_clock_disable) == $past(global_clock_disable, 2))
        |-> $stable(cpu_clk)) else $error("cpu clock moved without idle");
    a_periph_on_write: assert property (!$past(wr_ap, 3) |-> $stable(periph_clk))
        else $error("peripheral clock moved without write");
    a_read_idle_zero: assert property (!$past(rd_ap) |-> hrdata == 32'h0)
        else $error("read data outside read data phase");
    a_cfg_top_zero: assert property (
        $past(rd_ap && (haddr[31:2] == 30'h1 || haddr[31:2] == 30'h2))
        |-> hrdata[31:10] == 22'h0)
        else $error("reserved gating bits read nonzero");
    a_ahb_okay: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
endmodule // dcgc_chk
bind dcgc_top dcgc_chk #(.PERIPH_N(PERIPH_N)) chk_u (.hclk, .hresetn, .hsel, .hwrite,
    .hready, .hreadyout, .hresp, .idle_exec, .ctl_clk, .global_clock_disable, .haddr,
    .hrdata, .htrans, .cpu_clk, .periph_clk);
`default_nettype wire

// [tb/dcgc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcgc_map.vh"
// ============================================================
// Bench for the clock gating block
module dcgc_top_test;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle_exec = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, periph_clk;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, ctl_clk, global_clock_disable;
    logic [5:0]  cpu_clk;
    int          err_total = 0, samples_checked = 0;
    dcgc_top #(.PERIPH_N(32)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .idle_exec,
        .cpu_clk, .periph_clk, .ctl_clk, .global_clock_disable);
    always #2.5 hclk = ~hclk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // One single AHB transfer; read data taken at the closing edge
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Gated clocks are looked at in the high phase of hclk
    task automatic clk_chk(input logic [5:0] c, input logic [31:0] p);
        @(posedge hclk);
        #1;
        chk("cpu_clk", {26'h0, c}, {26'h0, cpu_clk});
        chk("periph_clk", p, periph_clk);
    endtask
    task automatic idle_pulse();
        @(posedge hclk);
        idle_exec <= 1'b1;
        @(posedge hclk);
        idle_exec <= 1'b0;
    endtask
    task automatic t_idle();
        logic [31:0] r;
        int          pos [6];
        pos = '{0, 5, 6, 7, 8, 9};
        bus(1'b1, 32'h4, 32'hffff, r);
        bus(1'b0, 32'h4, 32'h0, r);
        chk("config", `DCGC_CFG_MASK, r);
        clk_chk(6'h3f, 32'hffff_ffff);
        bus(1'b0, 32'h8, 32'h0, r);
        chk("status", 32'h0, r);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 32'h4, 32'h1 << pos[i], r);
            idle_pulse();
            clk_chk(~(6'h1 << i), 32'hffff_ffff);
            bus(1'b0, 32'h8, 32'h0, r);
            chk("status", 32'h1 << pos[i], r);
        end
        bus(1'b1, 32'h8, 32'hffff, r);
        bus(1'b0, 32'h8, 32'h0, r);
        chk("status", 32'h200, r);
        bus(1'b1, 32'h4, 32'h0, r);
        idle_pulse();
        clk_chk(6'h3f, 32'hffff_ffff);
    endtask
    task automatic t_periph();
        logic [31:0] r;
        bus(1'b1, 32'hc, 32'h7fff, r);
        bus(1'b1, 32'h10, 32'hffff, r);
        clk_chk(6'h3f, 32'h0000_8000);
        bus(1'b1, 32'hc, 32'h0001, r);
        bus(1'b1, 32'h10, 32'h8000, r);
        clk_chk(6'h3f, 32'h7fff_fffe);
        bus(1'b0, 32'hc, 32'h0, r);
        chk("periph_a", 32'h1, r);
        bus(1'b0, 32'h10, 32'h0, r);
        chk("periph_b", 32'h8000, r);
        bus(1'b1, 32'hc, 32'h8000, r);
        clk_chk(6'h00, 32'h0);
        chk("global_clock_disable", 32'h1, {31'h0, global_clock_disable});
        chk("ctl_clk", 32'h1, {31'h0, ctl_clk});
        bus(1'b1, 32'hc, 32'h0, r);
        clk_chk(6'h3f, 32'h7fff_ffff);
        chk("global_clock_disable", 32'h0, {31'h0, global_clock_disable});
        // Nonzero config so that an alias or a stray write would show
        bus(1'b1, 32'h4, 32'h3ff, r);
        bus(1'b0, 32'h0, 32'h0, r);
        chk("unmapped", 32'h0, r);
        bus(1'b1, 32'h24, 32'h0, r);
        bus(1'b0, 32'h24, 32'h0, r);
        chk("unmapped", 32'h0, r);
        bus(1'b0, 32'h4, 32'h0, r);
        chk("config", `DCGC_CFG_MASK, r);
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_idle();
        t_periph();
        stop_test();
    end
    // Tests need about 130 cycles; cut a hang at 6000, over forty times that
    initial begin
        #30000;
        err_total++;
        stop_test();
    end
endmodule // dcgc_top_test
`default_nettype wire
